/* rtl/agb_config_regs.sv */
/*
 Gain and bias configuration register bank with a Wishbone slave port,
 analog control outputs and an image load/store path to an EEPROM engine.
 Assumes an EEPROM engine outside that takes one byte request at a time.
*/
`timescale 1ns/1ps
module agb_config_regs
    import agb_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [ADDR_W-1:0]  wb_adr_i,
    input  wire logic [31:0]        wb_dat_i,
    input  wire logic [3:0]         wb_sel_i,
    output logic [31:0]             wb_dat_o,
    output logic                    wb_ack_o,
    output logic [1:0]              inputGainStage,
    output logic [1:0]              adcPgaGain,
    output logic                    ampABiasLink,
    output logic                    ampBBiasLink,
    output logic [3:0]              negBiasLevel,
    output logic [2:0]              ampABiasLevel,
    output logic [4:0]              ampBBiasLevel,
    output logic                    eeReq,
    output logic                    eeWrite,
    output logic [10:0]             eeAddr,
    output logic [7:0]              eeWrData,
    input  wire logic               eeDone,
    input  wire logic [7:0]         eeRdData
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] prodTest;
    logic [7:0] gainReg;
    logic [7:0] switchReg;
    logic [7:0] levelReg;
    logic [1:0] modeReg;

    logic        seqBusy;
    logic        seqReq;
    logic        seqWrite;
    logic [10:0] seqAddr;
    logic [1:0]  slot;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [7:0]  wordIdx  = wb_adr_i[ADDR_W-1:2];
    wire        wrLane0  = busReq && wb_we_i && wb_sel_i[0];
    wire [7:0]  wrByte   = wb_dat_i[7:0];
    wire        hitTest  = (wordIdx == IDX_PROD_TEST);
    wire        hitGain  = (wordIdx == IDX_GAIN);
    wire        hitSw    = (wordIdx == IDX_BIAS_SWITCH);
    wire        hitLvl   = (wordIdx == IDX_BIAS_LEVELS);
    wire        hitCtl   = (wordIdx == IDX_EE_CTRL);
    // Host writes to the image registers are held off during a load or a store, so
    // a transfer never mixes old and new settings.
    wire        hostWrOk = wrLane0 && !seqBusy;
    wire        startReq = wrLane0 && hitCtl && wrByte[CTL_START] && !seqBusy;
    wire        isStore  = (agb_mode_t'(wrByte[CTL_MODE_MSB:CTL_MODE_LSB])
                            == MODE_STORE);
    wire        isLoad   = (agb_mode_t'(wrByte[CTL_MODE_MSB:CTL_MODE_LSB])
                            == MODE_LOAD);
    wire        seqStart = startReq && (isStore || isLoad);
    wire        loadByte = seqBusy && !seqWrite && eeDone;

    wire [7:0]  ctlRead  = {3'h0, seqBusy, 2'h0, modeReg};
    wire [7:0]  rdByte   = hitTest ? prodTest :
                           hitGain ? (gainReg & GAIN_MASK) :
                           hitSw   ? (switchReg & SWITCH_MASK) :
                           hitLvl  ? levelReg :
                           hitCtl  ? ctlRead : 8'h00;
    wire [7:0]  imgByte  = (slot == 2'd0) ? gainReg :
                           (slot == 2'd1) ? switchReg : levelReg;

    // ------------------------------------------------------------
    // Image sequencer
    // ------------------------------------------------------------
    agb_image_seq u_seq (
        .ref_clk (ref_clk),
        .srst    (srst),
        .start   (seqStart),
        .isStore (isStore),
        .eeDone  (eeDone),
        .busy    (seqBusy),
        .eeReq   (seqReq),
        .eeWrite (seqWrite),
        .eeAddr  (seqAddr),
        .slot    (slot)
    );

    // ------------------------------------------------------------
    // Bus answer: registered ack one cycle after the request, every address acknowledged
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= busReq ? {24'h0, rdByte} : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // The production-test byte is kept as plain storage with no effect,
    // since software is forbidden to touch it.
    always_ff @(posedge ref_clk) begin
        if (srst) prodTest <= RST_PROD_TEST;
        else if (hostWrOk && hitTest) prodTest <= wrByte;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gainReg   <= RST_GAIN;
            switchReg <= RST_SWITCH;
            levelReg  <= RST_LEVELS;
            modeReg   <= 2'b00;
        end else begin
            if (loadByte && slot == 2'd0) gainReg <= eeRdData & GAIN_MASK;
            else if (hostWrOk && hitGain) gainReg <= wrByte & GAIN_MASK;
            if (loadByte && slot == 2'd1) switchReg <= eeRdData & SWITCH_MASK;
            else if (hostWrOk && hitSw) switchReg <= wrByte & SWITCH_MASK;
            if (loadByte && slot == 2'd2) levelReg <= eeRdData;
            else if (hostWrOk && hitLvl) levelReg <= wrByte;
            if (startReq) modeReg <= wrByte[CTL_MODE_MSB:CTL_MODE_LSB];
        end
    end

    // ------------------------------------------------------------
    // Analog controls and EEPROM request, all registered
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            inputGainStage <= 2'b00;
            adcPgaGain     <= 2'b00;
            ampABiasLink   <= 1'b0;
            ampBBiasLink   <= 1'b0;
            negBiasLevel   <= 4'h0;
            ampABiasLevel  <= 3'h0;
            ampBBiasLevel  <= 5'h00;
            eeReq          <= 1'b0;
            eeWrite        <= 1'b0;
            eeAddr         <= 11'h000;
            eeWrData       <= 8'h00;
        end else begin
            inputGainStage <= gainReg[GAIN_PRE_MSB:GAIN_PRE_LSB];
            adcPgaGain     <= gainReg[GAIN_ADC_MSB:GAIN_ADC_LSB];
            ampABiasLink   <= switchReg[SW_LINK_A];
            ampBBiasLink   <= switchReg[SW_LINK_B];
            negBiasLevel   <= switchReg[SW_NEG_MSB:SW_NEG_LSB];
            ampABiasLevel  <= levelReg[LVL_A_MSB:LVL_A_LSB];
            ampBBiasLevel  <= levelReg[LVL_B_MSB:LVL_B_LSB];
            eeReq          <= seqReq;
            eeWrite        <= seqWrite;
            eeAddr         <= seqAddr;
            eeWrData       <= imgByte;
        end
    end

endmodule

/* rtl/agb_pkg.sv */
/*
 Package for the gain and bias configuration bank: register word indices, field
 positions, reset values, EEPROM image addresses and transfer modes.
 Assumes a classic Wishbone slave with 32-bit data, one register a word.
*/
package agb_pkg;

    // --------------------------------------------------------------
    // Register indices and byte address width
    // --------------------------------------------------------------
    localparam logic [7:0] IDX_PROD_TEST   = 8'h0d;
    localparam logic [7:0] IDX_GAIN        = 8'h0e;
    localparam logic [7:0] IDX_BIAS_SWITCH = 8'h0f;
    localparam logic [7:0] IDX_BIAS_LEVELS = 8'h10;
    localparam logic [7:0] IDX_EE_CTRL     = 8'h20;
    localparam logic [7:0] IDX_EE_PORT     = 8'h21;
    localparam int         ADDR_W          = 10;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int GAIN_PRE_LSB  = 2;
    localparam int GAIN_PRE_MSB  = 3;
    localparam int GAIN_ADC_LSB  = 0;
    localparam int GAIN_ADC_MSB  = 1;
    localparam int SW_LINK_A     = 5;
    localparam int SW_LINK_B     = 4;
    localparam int SW_NEG_LSB    = 0;
    localparam int SW_NEG_MSB    = 3;
    localparam int LVL_A_LSB     = 5;
    localparam int LVL_A_MSB     = 7;
    localparam int LVL_B_LSB     = 0;
    localparam int LVL_B_MSB     = 4;
    localparam logic [7:0] GAIN_MASK   = 8'h0f;
    localparam logic [7:0] SWITCH_MASK = 8'h3f;

    // Control register: mode [1:0], start [2], busy [4].
    localparam int CTL_MODE_LSB  = 0;
    localparam int CTL_MODE_MSB  = 1;
    localparam int CTL_START     = 2;
    localparam int CTL_BUSY      = 4;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [7:0] RST_PROD_TEST = 8'h00;
    localparam logic [7:0] RST_GAIN      = 8'h00;
    localparam logic [7:0] RST_SWITCH    = 8'h00;
    localparam logic [7:0] RST_LEVELS    = 8'h00;

    // --------------------------------------------------------------
    // EEPROM image addresses and access modes
    // --------------------------------------------------------------
    localparam logic [10:0] EE_GAIN   = 11'h000;
    localparam logic [10:0] EE_SWITCH = 11'h001;
    localparam logic [10:0] EE_LEVELS = 11'h002;
    localparam int          IMG_COUNT = 3;

    typedef enum logic [1:0] {
        MODE_READ_BYTE  = 2'b00,
        MODE_WRITE_BYTE = 2'b01,
        MODE_LOAD       = 2'b10,
        MODE_STORE      = 2'b11
    } agb_mode_t;

endpackage

/* rtl/agb_image_seq.sv */
/*
 Image sequencer: walks the three image bytes in order for a load or a
 store, one byte request at a time, waiting for the EEPROM engine.
 Assumes an engine outside that answers each request with a done pulse.
*/
`timescale 1ns/1ps
module agb_image_seq
    import agb_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        start,
    input  wire logic        isStore,
    input  wire logic        eeDone,
    output logic             busy,
    output logic             eeReq,
    output logic             eeWrite,
    output logic [10:0]      eeAddr,
    output logic [1:0]       slot
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ  = 2'b01,
        ST_WAIT = 2'b10
    } agb_seq_t;

    agb_seq_t state;
    agb_seq_t next_state;
    logic     storeMode;
    logic     lastSlot;

    // ------------------------------------------------------------
    // Fixed slot to image byte mapping
    // ------------------------------------------------------------
    assign lastSlot = (slot == 2'(IMG_COUNT - 1));
    assign eeAddr   = (slot == 2'd0) ? EE_GAIN :
                      (slot == 2'd1) ? EE_SWITCH : EE_LEVELS;
    assign busy     = (state != ST_IDLE);
    assign eeReq    = (state == ST_REQ);
    assign eeWrite  = storeMode;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: if (start) next_state = ST_REQ;
            ST_REQ:  next_state = ST_WAIT;
            ST_WAIT: if (eeDone) next_state = lastSlot ? ST_IDLE : ST_REQ;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state     <= ST_IDLE;
            slot      <= 2'd0;
            storeMode <= 1'b0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && start) begin
                slot      <= 2'd0;
                storeMode <= isStore;
            end else if (state == ST_WAIT && eeDone && !lastSlot) begin
                slot <= slot + 2'd1;
            end
        end
    end

endmodule

/* test/agb_config_regs_asserts.sv */
/*
 Checker for the gain and bias bank: bus handshake, field outputs and
 image transfer start. Assumes it is bound to agb_config_regs.
*/
`timescale 1ns/1ps
module agb_config_regs_asserts
    import agb_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              srst,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [1:0]        inputGainStage,
    input wire logic [1:0]        adcPgaGain,
    input wire logic              ampABiasLink,
    input wire logic              eeReq,
    input wire logic              eeWrite,
    input wire logic [10:0]       eeAddr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // An image write only lands while no transfer runs; the bench keeps
    // its register writes outside transfers.
    sequence s_wr(logic [7:0] ix);
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
            && wb_adr_i[9:2] == ix;
    endsequence
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not acked");
    a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data without ack");
    a_upper_zero: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
    a_pre_gain: assert property (s_wr(IDX_GAIN) |-> ##2
        inputGainStage == $past(wb_dat_i[3:2], 2)) else $error("pre gain");
    a_adc_gain: assert property (s_wr(IDX_GAIN) |-> ##2
        adcPgaGain == $past(wb_dat_i[1:0], 2)) else $error("adc gain");
    a_link_a: assert property (s_wr(IDX_BIAS_SWITCH) |-> ##2
        ampABiasLink == $past(wb_dat_i[5], 2)) else $error("link a");
    a_load_start: assert property (s_wr(IDX_EE_CTRL) ##0
        wb_dat_i[2:0] == 3'b110 |-> ##[1:4] eeReq && !eeWrite
        && eeAddr == EE_GAIN) else $error("load did not start");
    a_store_start: assert property (s_wr(IDX_EE_CTRL) ##0
        wb_dat_i[2:0] == 3'b111 |-> ##[1:4] eeReq && eeWrite
        && eeAddr == EE_GAIN) else $error("store did not start");
    a_req_pulse: assert property (eeReq |=> !eeReq)
        else $error("eeprom request too long");
    c_gain_wr: cover property (s_wr(IDX_GAIN));
    c_store: cover property (eeReq && eeWrite);
    c_load: cover property (eeReq && !eeWrite);
endmodule

bind agb_config_regs agb_config_regs_asserts u_chk (
    .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .inputGainStage(inputGainStage),
    .adcPgaGain(adcPgaGain), .ampABiasLink(ampABiasLink),
    .eeReq(eeReq), .eeWrite(eeWrite), .eeAddr(eeAddr));

/* test/agb_tb.sv */
/*
 Self-checking bench for the gain and bias bank against an integer model.
 Assumes agb_pkg and the checker are compiled before it.
*/
`timescale 1ns/1ps
module tb;
    import agb_pkg::*;
    logic ref_clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, eeDone = 0;
    logic [ADDR_W-1:0] adr = '0;
    logic [31:0] dwr = '0, rdat, drd, seed = 32'h22375006;
    logic [3:0] sel = '0;
    logic [7:0] eeRdData = '0, eeWrData;
    logic ack, eeReq, eeWrite, linkA, linkB;
    logic [1:0] preGain, adcGain;
    logic [3:0] negBias;
    logic [2:0] lvlA;
    logic [4:0] lvlB;
    logic [10:0] eeAddr;
    int failures = 0, cmp_count = 0, cycles = 0, idx, mdl[4];
    int msk[4] = '{255, 15, 63, 255};

    agb_config_regs DUT (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dwr),
        .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .inputGainStage(preGain), .adcPgaGain(adcGain), .ampABiasLink(linkA),
        .ampBBiasLink(linkB), .negBiasLevel(negBias), .ampABiasLevel(lvlA),
        .ampBBiasLevel(lvlB), .eeReq(eeReq), .eeWrite(eeWrite),
        .eeAddr(eeAddr), .eeWrData(eeWrData), .eeDone(eeDone),
        .eeRdData(eeRdData));

    always #5 ref_clk = ~ref_clk;
    // A hang in any wait ends here as a mismatch.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Random upper data bits show that only the low byte is taken.
    task automatic bus(logic w, logic [7:0] ix, logic [7:0] d, logic s0);
        @(posedge ref_clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {ix, 2'b00};
        dwr <= {seed[31:8], d};
        sel <= {3'b101, s0};
        do @(posedge ref_clk); while (ack !== 1'b1);
        drd = rdat;
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic rd(string n, logic [7:0] ix, int e);
        bus(0, ix, 8'h00, 1);
        check(n, drd, e);
    endtask
    task automatic outs();
        @(negedge ref_clk);
        check("preGain", preGain, mdl[1][3:2]);
        check("adcGain", adcGain, mdl[1][1:0]);
        check("linkA", linkA, mdl[2][5]);
        check("linkB", linkB, mdl[2][4]);
        check("negBias", negBias, mdl[2][3:0]);
        check("lvlA", lvlA, mdl[3][7:5]);
        check("lvlB", lvlB, mdl[3][4:0]);
    endtask
    // The engine answers each byte one cycle after the request.
    task automatic serve(logic st);
        for (int k = 0; k < 3; k++) begin
            do @(negedge ref_clk); while (eeReq !== 1'b1);
            check("eeAddr", eeAddr, k);
            check("eeWrite", eeWrite, st);
            if (st) check("eeWrData", eeWrData, mdl[k + 1]);
            seed = lfsr(seed);
            @(posedge ref_clk);
            eeDone <= 1;
            eeRdData <= seed[7:0];
            if (!st) mdl[k + 1] = seed[7:0] & msk[k + 1];
            @(posedge ref_clk);
            eeDone <= 0;
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        srst <= 0;
        for (idx = 0; idx < 4; idx++) rd("reset", 8'h0d + idx[7:0], 0);
        outs();
        repeat (30) begin
            seed = lfsr(seed);
            idx = 1 + seed[1:0] % 3;
            bus(1, 8'h0d + idx[7:0], seed[15:8], seed[20]);
            if (seed[20]) mdl[idx] = seed[15:8] & msk[idx];
            rd("readback", 8'h0d + idx[7:0], mdl[idx]);
            outs();
        end
        bus(1, IDX_EE_PORT, 8'hff, 1);
        rd("unmapped", IDX_EE_PORT, 0);
        bus(1, IDX_EE_CTRL, 8'h05, 1);
        rd("noseq", IDX_EE_CTRL, 1);
        bus(1, IDX_EE_CTRL, 8'h07, 1);
        serve(1);
        rd("ctrl", IDX_EE_CTRL, 3);
        bus(1, IDX_EE_CTRL, 8'h06, 1);
        serve(0);
        for (idx = 1; idx < 4; idx++) rd("load", 8'h0d + idx[7:0], mdl[idx]);
        outs();
        // A second reset mid-run must clear every field again.
        @(posedge ref_clk);
        srst <= 1;
        repeat (2) @(posedge ref_clk);
        srst <= 0;
        for (idx = 0; idx < 4; idx++) mdl[idx] = 0;
        for (idx = 0; idx < 4; idx++) rd("rst2", 8'h0d + idx[7:0], 0);
        outs();
        tally_and_finish();
    end
endmodule
